// File: common/mcc_map.svh
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCC_MODE_ADDR       8'h16
`define MCC_CFG_ADDR        8'h40
`define MCC_CFG2_ADDR       8'h4A
`define MCC_VID_ADDR        8'h47
`define MCC_VAL_BASE        8'h20
`define MCC_VAL_LAST        8'h28

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MCC_MODE_TACH_A     0
`define MCC_MODE_TACH_B     1
`define MCC_MODE_DIODE_B    2
`define MCC_MODE_VCC_5V     3
`define MCC_MODE_IRQ_MODE   7
`define MCC_CFG_START       0
`define MCC_CFG_INT_CLEAR   3
`define MCC_MODE_RESET      8'h00
`define MCC_CFG_RESET       8'h00
`define MCC_CFG2_RESET      8'h00

// ----------------------------------------------------------------
// Channel numbers
// ----------------------------------------------------------------
`define MCC_CH_SHARED_A     0
`define MCC_CH_SHARED_B     1
`define MCC_CH_PAIR_LO      2
`define MCC_CH_PAIR_HI      3
`define MCC_CH_DIODE_A      8
`define MCC_NUM_CH          9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCC_CLK_PERIOD_NS   10
`define MCC_CONV_PERIOD_US  748
`define MCC_DIODE_MEAS_US   9600
`define MCC_DIODE_SAMPLES   16
`define MCC_CONV_CYCLES     ((`MCC_CONV_PERIOD_US * 1000) / `MCC_CLK_PERIOD_NS)
`define MCC_DIODE_CYCLES    ((`MCC_DIODE_MEAS_US * 1000) / (`MCC_DIODE_SAMPLES * `MCC_CLK_PERIOD_NS))

`endif

// File: common/mcc_pkg.sv
package mcc_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MCC_IDLE  = 2'h0,
      MCC_ISSUE = 2'h1,
      MCC_BUSY  = 2'h3,
      MCC_PACE  = 2'h2
   } mcc_fsm_type;

   typedef struct packed {
      mcc_fsm_type     fsm;
      logic [3:0]      chan;
      logic [3:0]      samples;
      logic [7:0]      mode;
      logic [7:0]      cfg;
      logic [7:0]      cfg2;
      logic [8:0][7:0] vals;
      logic [7:0]      rdata;
      logic [4:0]      vid;
      logic [4:0]      irq;
   } mcc_state_type;

   typedef struct packed {
      logic [19:0] count;
   } mcc_timer_type;

   typedef struct packed {
      logic [11:0] acc;
      logic [3:0]  count;
      logic [7:0]  avg;
      logic        valid;
   } mcc_avg_type;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mcc_reg_req_type;

endpackage : mcc_pkg

// File: verilog/mcc_pace_timer.sv
`timescale 1ns/1ps
`include "mcc_map.svh"
module mcc_pace_timer
   import mcc_pkg::*;
(
   input  logic        clk_i,
   input  logic        sys_rst_i,
   input  logic        load_i,
   input  logic [19:0] period_i,
   output logic        expired_o
);

   mcc_timer_type st;
   mcc_timer_type next_st;

   always_comb begin
      next_st = st;
      // Loaded during the start cycle: minus two puts the next start exactly period cycles later
      // Limitation: periods below two are not supported
      if (load_i) begin
         next_st.count = period_i - 20'h00002;
      end else if (st.count != 20'h00000) begin
         next_st.count = st.count - 20'h00001;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired_o = (st.count == 20'h00000);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_timer_reload: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      load_i |=> st.count == $past(period_i) - 20'h00002)
      else $error("pace timer did not reload");
   a_timer_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!load_i && !expired_o) |=> st.count == $past(st.count) - 20'h00001)
      else $error("pace timer did not count down");

endmodule : mcc_pace_timer

// File: verilog/mcc_diode_avg.sv
`timescale 1ns/1ps
`include "mcc_map.svh"
module mcc_diode_avg
   import mcc_pkg::*;
(
   input  logic       clk_i,
   input  logic       sys_rst_i,
   input  logic       clear_i,
   input  logic       add_i,
   input  logic [7:0] sample_i,
   output logic [7:0] avg_o,
   output logic       valid_o
);

   mcc_avg_type st;
   mcc_avg_type next_st;
   logic [11:0] sum;

   // Signed sum of sixteen samples fits twelve bits without overflow
   assign sum = st.acc + {{4{sample_i[7]}}, sample_i};

   always_comb begin
      next_st       = st;
      next_st.valid = 1'b0;
      if (clear_i) begin
         next_st.acc   = 12'h000;
         next_st.count = 4'h0;
      end else if (add_i) begin
         next_st.count = st.count + 4'h1;
         if (st.count == 4'hF) begin
            next_st.avg   = sum[11:4];
            next_st.valid = 1'b1;
            next_st.acc   = 12'h000;
         end else begin
            next_st.acc = sum;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign avg_o   = st.avg;
   assign valid_o = st.valid;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_avg_sixteen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      valid_o |-> $past(st.count) == 4'hF && $past(add_i) && !$past(clear_i))
      else $error("average produced before sixteen samples");
   a_avg_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (add_i && !clear_i && st.count == 4'hF) |=> avg_o == $past(sum[11:4]))
      else $error("average value wrong");
   a_avg_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      clear_i |=> st.count == 4'h0 && st.acc == 12'h000 && !valid_o)
      else $error("averager not cleared");

endmodule : mcc_diode_avg

// File: verilog/mcc_channel_ctrl.sv
`timescale 1ns/1ps
`include "mcc_map.svh"
module mcc_channel_ctrl
   import mcc_pkg::*;
#(
   parameter logic [19:0] CONV_CYCLES  = 20'(`MCC_CONV_CYCLES),
   parameter logic [19:0] DIODE_CYCLES = 20'(`MCC_DIODE_CYCLES)
)(
   input  logic       clk_i,
   input  logic       sys_rst_i,
   input  logic       reg_wr_i,
   input  logic [7:0] reg_addr_i,
   input  logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input  logic [4:0] volt_id_pins_i,
   output logic [4:0] volt_id_o,
   output logic [4:0] ext_irq_o,
   output logic       tach_in_a_en_o,
   output logic       tach_in_b_en_o,
   output logic       diode_b_sel_o,
   output logic       vcc_range_5v_o,
   output logic       adc_start_o,
   output logic [3:0] adc_chan_o,
   output logic       adc_diode_o,
   input  logic       adc_done_i,
   input  logic [7:0] adc_code_i
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mcc_state_type   st;
   mcc_state_type   next_st;
   mcc_reg_req_type req;
   logic [8:0]      chan_mask;
   logic [4:0]      irq_en;
   logic            running;
   logic            diode_now;
   logic            pace_load;
   logic [19:0]     pace_period;
   logic            pace_expired;
   logic            avg_clear;
   logic            avg_add;
   logic [7:0]      avg_value;
   logic            avg_valid;
   logic [3:0]      val_idx;

   assign req.wr    = reg_wr_i;
   assign req.addr  = reg_addr_i;
   assign req.wdata = reg_wdata_i;

   // ----------------------------------------------------------------
   // Channel plan
   // ----------------------------------------------------------------
   // Channels 4..8 are the dedicated inputs and the supply; they are always converted
   generate
      for (genvar g = 0; g < `MCC_NUM_CH; g++) begin : g_mask
         if (g == `MCC_CH_SHARED_A) begin : g_a
            assign chan_mask[g] = st.mode[`MCC_MODE_TACH_A];
         end else if (g == `MCC_CH_SHARED_B) begin : g_b
            assign chan_mask[g] = st.mode[`MCC_MODE_TACH_B];
         end else if (g == `MCC_CH_PAIR_HI) begin : g_hi
            assign chan_mask[g] = !st.mode[`MCC_MODE_DIODE_B];
         end else begin : g_fixed
            assign chan_mask[g] = 1'b1;
         end
      end
   endgenerate

   // Diode b replaces the 2.5 V input on the low pin; diode a is fixed
   assign diode_now = (st.chan == 4'(`MCC_CH_DIODE_A)) ||
                      (st.chan == 4'(`MCC_CH_PAIR_LO) && st.mode[`MCC_MODE_DIODE_B]);

   assign running = st.cfg[`MCC_CFG_START] && !st.cfg[`MCC_CFG_INT_CLEAR];

   function automatic logic [3:0] mcc_next_chan(input logic [3:0] cur, input logic [8:0] mask);
      logic [3:0] res;
      int         c;
      res = cur;
      c   = 0;
      for (int k = `MCC_NUM_CH - 1; k >= 1; k--) begin
         c = (int'(cur) + k) % `MCC_NUM_CH;
         if (mask[c]) begin
            res = 4'(c);
         end
      end
      return res;
   endfunction : mcc_next_chan

   // ----------------------------------------------------------------
   // Interrupt-input enables
   // ----------------------------------------------------------------
   // Bit order follows the ID pins: index 0 is the first ID bit
   assign irq_en = {st.cfg2[7], st.cfg2[6], st.mode[6:4]};

   assign val_idx = 4'(req.addr - `MCC_VAL_BASE);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Register writes
      if (req.wr) begin
         case (req.addr)
            `MCC_MODE_ADDR: begin
               next_st.mode = req.wdata;
            end
            `MCC_CFG_ADDR: begin
               next_st.cfg = req.wdata;
            end
            `MCC_CFG2_ADDR: begin
               next_st.cfg2 = req.wdata;
            end
            default: begin
            end
         endcase
      end

      // Register reads, one cycle behind the address
      case (req.addr)
         `MCC_MODE_ADDR: next_st.rdata = st.mode;
         `MCC_CFG_ADDR:  next_st.rdata = st.cfg;
         `MCC_CFG2_ADDR: next_st.rdata = st.cfg2;
         `MCC_VID_ADDR:  next_st.rdata = {3'h0, st.vid};
         default: begin
            if (req.addr >= `MCC_VAL_BASE && req.addr <= `MCC_VAL_LAST) begin
               next_st.rdata = st.vals[val_idx];
            end else begin
               next_st.rdata = 8'h00;
            end
         end
      endcase

      // Pin function: ID bits or interrupt inputs
      if (st.mode[`MCC_MODE_IRQ_MODE]) begin
         next_st.vid = 5'h00;
         next_st.irq = volt_id_pins_i & irq_en;
      end else begin
         next_st.vid = volt_id_pins_i;
         next_st.irq = 5'h00;
      end

      // Result from the averager lands in the diode channel's slot
      if (avg_valid) begin
         next_st.vals[st.chan] = avg_value;
      end

      // Sequencer
      case (st.fsm)
         MCC_IDLE: begin
            next_st.samples = 4'h0;
            if (running) begin
               next_st.fsm = MCC_ISSUE;
               if (!chan_mask[st.chan]) begin
                  next_st.chan = mcc_next_chan(st.chan, chan_mask);
               end
            end
         end
         MCC_ISSUE: begin
            next_st.fsm = MCC_BUSY;
         end
         MCC_BUSY: begin
            if (adc_done_i) begin
               next_st.fsm = MCC_PACE;
               if (diode_now) begin
                  next_st.samples = st.samples + 4'h1;
               end else begin
                  // The converter code is already clamped to 0..255 full range
                  next_st.vals[st.chan] = adc_code_i;
               end
            end
         end
         MCC_PACE: begin
            if (pace_expired) begin
               if (!running) begin
                  next_st.fsm = MCC_IDLE;
               end else if (diode_now && st.samples != 4'h0) begin
                  next_st.fsm = MCC_ISSUE;
               end else begin
                  next_st.fsm  = MCC_ISSUE;
                  next_st.chan = mcc_next_chan(st.chan, chan_mask);
               end
            end
         end
         default: begin
            next_st.fsm = MCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st      <= '0;
         st.mode <= `MCC_MODE_RESET;
         st.cfg  <= `MCC_CFG_RESET;
         st.cfg2 <= `MCC_CFG2_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Pacing and averaging
   // ----------------------------------------------------------------
   // A slot is paced from the start pulse; only a done arriving more than period minus two cycles after it stretches the rate
   assign pace_load   = (st.fsm == MCC_ISSUE);
   assign pace_period = diode_now ? DIODE_CYCLES : CONV_CYCLES;

   mcc_pace_timer u_pace (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (pace_load),
      .period_i  (pace_period),
      .expired_o (pace_expired)
   );

   // Stopping mid-average discards the partial sum
   assign avg_clear = (st.fsm == MCC_IDLE);
   assign avg_add   = (st.fsm == MCC_BUSY) && adc_done_i && diode_now;

   mcc_diode_avg u_avg (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (avg_clear),
      .add_i     (avg_add),
      .sample_i  (adc_code_i),
      .avg_o     (avg_value),
      .valid_o   (avg_valid)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o    = st.rdata;
   assign volt_id_o      = st.vid;
   assign ext_irq_o      = st.irq;
   assign tach_in_a_en_o = !st.mode[`MCC_MODE_TACH_A];
   assign tach_in_b_en_o = !st.mode[`MCC_MODE_TACH_B];
   assign diode_b_sel_o  = st.mode[`MCC_MODE_DIODE_B];
   assign vcc_range_5v_o = st.mode[`MCC_MODE_VCC_5V];
   assign adc_start_o    = (st.fsm == MCC_ISSUE);
   assign adc_chan_o     = st.chan;
   assign adc_diode_o    = diode_now;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_tach_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == `MCC_MODE_ADDR) |=>
         {tach_in_b_en_o, tach_in_a_en_o} == ~$past(reg_wdata_i[1:0]))
      else $error("tach select does not follow mode write");
   a_pair_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == `MCC_MODE_ADDR) |=>
         diode_b_sel_o == $past(reg_wdata_i[2]) && vcc_range_5v_o == $past(reg_wdata_i[3]))
      else $error("pair or supply range select wrong");
   a_vid_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !st.mode[`MCC_MODE_IRQ_MODE] |=> volt_id_o == $past(volt_id_pins_i) && ext_irq_o == 5'h00)
      else $error("ID pins not passed in ID mode");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      st.mode[`MCC_MODE_IRQ_MODE] |=>
         ext_irq_o == ($past(volt_id_pins_i) & {$past(st.cfg2[7:6]), $past(st.mode[6:4])})
         && volt_id_o == 5'h00)
      else $error("interrupt input gating wrong");
   a_fixed_chans: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      chan_mask[8:4] == 5'h1F)
      else $error("dedicated channel dropped");
   a_skip_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      adc_start_o |-> chan_mask[adc_chan_o])
      else $error("conversion started on a non-analog pin");
   a_start_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      adc_start_o |=> !adc_start_o ##0 st.fsm == MCC_BUSY)
      else $error("start pulse too long");
   a_store_now: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st.fsm == MCC_BUSY && adc_done_i && !diode_now) |=> st.vals[$past(st.chan)] == $past(adc_code_i))
      else $error("result not stored on completion");
   a_stop_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (st.fsm == MCC_IDLE && !running) |=> st.fsm == MCC_IDLE)
      else $error("sequencer ran while stopped");
   a_pace_period: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (adc_start_o && !diode_now) |-> pace_period == CONV_CYCLES)
      else $error("ordinary slot period wrong");

endmodule : mcc_channel_ctrl

// File: test/mcc_adc_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Converter stand-in: fixed code per channel, ramp of signed codes on diode channels
// ----------------------------------------------------------------
module mcc_adc_model (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       start_i,
   input  wire logic [3:0] chan_i,
   input  wire logic       diode_i,
   input  wire logic [7:0] latency_i,
   output logic            done_o,
   output logic [7:0]      code_o
);
   logic [7:0] wait_cnt;
   logic       busy;
   logic [3:0] last_chan;
   logic [3:0] idx;
   logic [7:0] result;
   logic [3:0] n;
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy      <= 1'b0;
         done_o    <= 1'b0;
         code_o    <= 8'hA5;
         wait_cnt  <= 8'h00;
         last_chan <= 4'hF;
         idx       <= 4'h0;
         result    <= 8'h00;
      end else if (start_i) begin
         n = (diode_i && chan_i == last_chan) ? idx + 4'h1 : 4'h0;
         idx       <= n;
         last_chan <= chan_i;
         busy      <= 1'b1;
         wait_cnt  <= latency_i;
         done_o    <= 1'b0;
         code_o    <= ~code_o;
         // Diode samples run -8..7 so the average needs a signed floor
         if (diode_i) begin
            result <= {4'h0, n} - 8'h08;
         end else begin
            result <= (chan_i == 4'h0) ? 8'hFF : (chan_i == 4'h1) ? 8'hC0 : 8'h40 + {4'h0, chan_i};
         end
      end else if (busy && wait_cnt <= 8'h01) begin
         busy   <= 1'b0;
         done_o <= 1'b1;
         code_o <= result;
      end else begin
         wait_cnt <= wait_cnt - 8'h01;
         done_o   <= 1'b0;
         // Result is only held with done; toggle so a late sample is caught
         code_o   <= ~code_o;
      end
   end
endmodule : mcc_adc_model

// File: test/measurement_channel_config_tb.sv
`timescale 1ns/1ps
`include "mcc_map.svh"
module measurement_channel_config_tb;
   import mcc_pkg::*;
   localparam int CONV  = 20;
   localparam int DIODE = 30;
   localparam int LIMIT = 20000;
   logic clk_i, sys_rst_i, reg_wr_i, adc_done_i, adc_start_o, adc_diode_o;
   logic tach_in_a_en_o, tach_in_b_en_o, diode_b_sel_o, vcc_range_5v_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, adc_code_i, lat;
   logic [4:0] volt_id_pins_i, volt_id_o, ext_irq_o;
   logic [3:0] adc_chan_o;
   logic [3:0] starts[$];
   int         fails, compares, cyc, nstart, last_cyc, n_rec;
   logic       rec, have_prev, prev_diode, prompt, diode_b_mode;

   mcc_channel_ctrl #(.CONV_CYCLES(20'(CONV)), .DIODE_CYCLES(20'(DIODE))) DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .volt_id_pins_i(volt_id_pins_i),
      .volt_id_o(volt_id_o), .ext_irq_o(ext_irq_o), .tach_in_a_en_o(tach_in_a_en_o),
      .tach_in_b_en_o(tach_in_b_en_o), .diode_b_sel_o(diode_b_sel_o), .vcc_range_5v_o(vcc_range_5v_o),
      .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o), .adc_diode_o(adc_diode_o),
      .adc_done_i(adc_done_i), .adc_code_i(adc_code_i));

   mcc_adc_model ADC (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(adc_start_o), .chan_i(adc_chan_o),
      .diode_i(adc_diode_o), .latency_i(lat), .done_o(adc_done_i), .code_o(adc_code_i));

   // ----------------------------------------------------------------
   // Clock, watchdog and start monitor
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (adc_start_o) begin
         nstart = nstart + 1;
         if (rec && starts.size() < n_rec) begin
            starts.push_back(adc_chan_o);
            check("diode flag", adc_diode_o, adc_chan_o == 4'h8 || (adc_chan_o == 4'h2 && diode_b_mode));
            if (have_prev && prompt) begin
               check("slot period", cyc - last_cyc, prev_diode ? DIODE : CONV);
            end else if (have_prev) begin
               check("stretched slot", (cyc - last_cyc) > lat, 1);
            end
            have_prev  = 1'b1;
            prev_diode = adc_diode_o;
            last_cyc   = cyc;
         end
      end
      if (cyc == LIMIT) begin
         fails = fails + 1;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("Error %s expected %0h seen %0h", n, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      reg_wr_i    = 1'b1;
      reg_addr_i  = a;
      reg_wdata_i = d;
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      #1;
      reg_addr_i = a;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
      check("register read", reg_rdata_o, e);
   endtask : rd

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cycles

   // Record n starts and compare them to the expected channel order
   task automatic run_seq(input logic [3:0] exp_q[$]);
      starts.delete();
      have_prev = 1'b0;
      n_rec     = exp_q.size();
      rec       = 1'b1;
      wr(`MCC_CFG_ADDR, 8'h01);
      while (starts.size() < n_rec) @(posedge clk_i);
      rec = 1'b0;
      foreach (exp_q[i]) check("channel order", starts[i], exp_q[i]);
      wr(`MCC_CFG_ADDR, 8'h00);
      wait_cycles(100);
   endtask : run_seq

   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [3:0] q[$];
      logic [7:0] m;
      fails = 0; compares = 0; cyc = 0; nstart = 0; last_cyc = 0; n_rec = 0;
      rec = 1'b0; have_prev = 1'b0; prev_diode = 1'b0; prompt = 1'b1; diode_b_mode = 1'b0;
      sys_rst_i = 1'b1; reg_wr_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
      volt_id_pins_i = 5'h15; lat = 8'h03;
      wait_cycles(16);
      sys_rst_i = 1'b0;
      rd(`MCC_MODE_ADDR, 8'h00);
      rd(`MCC_CFG2_ADDR, 8'h00);
      check("mode outputs", {tach_in_a_en_o, tach_in_b_en_o, diode_b_sel_o, vcc_range_5v_o}, 4'hC);
      for (int b = 0; b < 4; b++) begin
         m = 8'h01 << b;
         wr(`MCC_MODE_ADDR, m);
         rd(`MCC_MODE_ADDR, m);
         check("mode outputs", {tach_in_a_en_o, tach_in_b_en_o, diode_b_sel_o, vcc_range_5v_o}, {~m[0], ~m[1], m[2], m[3]});
      end
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      // Identification pins versus interrupt inputs
      wr(`MCC_MODE_ADDR, 8'h00);
      rd(`MCC_VID_ADDR, 8'h15);
      check("id bits", volt_id_o, 5'h15);
      check("irq inputs", ext_irq_o, 5'h00);
      wr(`MCC_MODE_ADDR, 8'hF0);
      wr(`MCC_CFG2_ADDR, 8'hC0);
      wait_cycles(2);
      check("id bits", volt_id_o, 5'h00);
      check("irq inputs", ext_irq_o, 5'h15);
      volt_id_pins_i = 5'h1F;
      wr(`MCC_MODE_ADDR, 8'hA0);
      wr(`MCC_CFG2_ADDR, 8'h80);
      wait_cycles(2);
      check("irq inputs", ext_irq_o, 5'h12);
      rd(`MCC_CFG2_ADDR, 8'h80);
      // Fan pins skipped, fixed channels always visited, diode a sampled sixteen times
      wr(`MCC_MODE_ADDR, 8'h00);
      q = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      repeat (16) q.push_back(4'h8);
      run_seq(q);
      for (int c = 2; c < 8; c++) rd(`MCC_VAL_BASE + 8'(c), 8'h40 + 8'(c));
      rd(`MCC_VAL_LAST, 8'hFF);
      rd(`MCC_VAL_BASE, 8'h00);
      nstart = 0;
      wait_cycles(200);
      check("stopped starts", nstart, 0);
      wr(`MCC_CFG_ADDR, 8'h09);
      wait_cycles(200);
      check("clear blocks run", nstart, 0);
      // Second reset mid-life, slow converter, pin b analog and diode b selected
      sys_rst_i = 1'b1;
      wait_cycles(2);
      sys_rst_i = 1'b0;
      rd(`MCC_CFG_ADDR, 8'h00);
      lat = 8'h2D;
      prompt = 1'b0;
      diode_b_mode = 1'b1;
      wr(`MCC_MODE_ADDR, 8'h06);
      q = '{4'h1};
      repeat (16) q.push_back(4'h2);
      q.push_back(4'h4);
      q.push_back(4'h5);
      run_seq(q);
      rd(`MCC_VAL_BASE + 8'h01, 8'hC0);
      rd(`MCC_VAL_BASE + 8'h02, 8'hFF);
      rd(`MCC_VAL_BASE + 8'h04, 8'h44);
      rd(`MCC_VAL_BASE, 8'h00);
      conclude();
   end
endmodule : measurement_channel_config_tb
